// *** logic/cssc_pkg.sv ***
package cssc_pkg;
	// ----------------------------------------
	// register map (byte addresses)
	// ----------------------------------------
	localparam logic [7:0] ADDR_MODE = 8'h00;
	localparam logic [7:0] ADDR_CTRL = 8'h04;
	localparam logic [7:0] ADDR_DATA = 8'h08;
	localparam logic [7:0] ADDR_STAT = 8'h0c;
	localparam logic [7:0] ADDR_MASK = 8'h10;
	localparam logic [7:0] ADDR_CLR = 8'h14;
	// ----------------------------------------
	// mode register fields and reset
	// ----------------------------------------
	localparam int MODE_OPCLK = 15;
	localparam int MODE_EXTCLK = 14;
	localparam int MODE_TRIG = 8;
	localparam int MODE_INV = 6;
	localparam int MODE_ISRC = 0;
	localparam logic [15:0] MODE_RESET = 16'h0020;
	localparam logic [15:0] MODE_MASK = 16'hc16f;
	// ----------------------------------------
	// control register fields and reset
	// ----------------------------------------
	localparam int CTRL_RXE = 14;
	localparam int CTRL_PHASE = 13;
	localparam int CTRL_POL = 12;
	localparam int CTRL_DIR = 7;
	localparam int CTRL_DLS0 = 0;
	localparam logic [15:0] CTRL_RESET = 16'h0007;
	localparam logic [15:0] CTRL_MASK = 16'hf087;
	// ----------------------------------------
	// status / event bits
	// ----------------------------------------
	localparam int STAT_FULL = 0;
	localparam int STAT_OVR = 1;
	localparam int STAT_BUSY = 2;
	localparam int EV_END = 0;
	localparam int EV_OVR = 1;
	localparam int EV_EMPTY = 2;
	localparam logic [2:0] EV_RESET = 3'h0;
	// ----------------------------------------
	// word lengths and link limits
	// ----------------------------------------
	localparam logic [3:0] LEN_SEVEN = 4'h7;
	localparam logic [3:0] LEN_EIGHT = 4'h8;
	localparam logic [3:0] CNT_ZERO = 4'h0;
	localparam int MIN_CLK_RATIO = 6;
	localparam int PCLK_PERIOD_NS = 5;
	localparam int MIN_SCLK_PERIOD_NS = MIN_CLK_RATIO * PCLK_PERIOD_NS;

	typedef struct packed {
		logic sclk;
		logic sdi;
	} cssc_link_t;

	typedef struct packed {
		logic end_of_xfer;
		logic overrun;
		logic empty;
	} cssc_event_t;

	typedef enum logic [1:0] {
		CSSC_IDLE = 2'b00,
		CSSC_SHIFT = 2'b01,
		CSSC_DONE = 2'b10
	} cssc_state_t;
endpackage : cssc_pkg

// *** logic/cssc_slave.sv ***
// Our own choices: the APB slave port and the placing of the registers.
`timescale 1ns/1ps
module cssc_slave #(
	parameter int DATA_W = 8
) (
	// apb
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// serial link
	input wire logic serial_clock_pin,
	input wire logic serial_data_in_pin,
	// interrupt
	output logic transfer_end_interrupt
);
	// ----------------------------------------
	// registers
	// ----------------------------------------
	logic [15:0] channel_mode_register;
	logic [15:0] communication_control_register;
	logic [DATA_W-1:0] channel_data_register;
	logic [DATA_W-1:0] shift;
	logic [3:0] bit_cnt;
	logic buffer_full_flag;
	logic busy;
	logic [2:0] ev_stat;
	logic [2:0] ev_mask;
	logic [2:0] ev_seen;
	logic data_fresh;
	cssc_pkg::cssc_link_t meta;
	cssc_pkg::cssc_link_t sync;
	logic sclk_d;
	cssc_pkg::cssc_state_t state;
	cssc_pkg::cssc_event_t ev;

	// ----------------------------------------
	// functions
	// ----------------------------------------
	function automatic logic [DATA_W-1:0] ins_bit(input logic [DATA_W-1:0] s,
		input logic b, input logic lsb_first, input logic [3:0] len);
		logic [DATA_W-1:0] r;
		r = s;
		if (lsb_first)
		begin
			r = {b, s[DATA_W-1:1]};
		end
		else
		begin
			r = {s[DATA_W-2:0], b};
		end
		return r;
	endfunction : ins_bit

	function automatic logic [DATA_W-1:0] align(input logic [DATA_W-1:0] s,
		input logic lsb_first, input logic [3:0] len);
		logic [DATA_W-1:0] r;
		r = s;
		if (lsb_first && len == cssc_pkg::LEN_SEVEN)
		begin
			r = {1'b0, s[DATA_W-1:1]};
		end
		else if (len == cssc_pkg::LEN_SEVEN)
		begin
			r = {1'b0, s[DATA_W-2:0]};
		end
		return r;
	endfunction : align

	// ----------------------------------------
	// decode
	// ----------------------------------------
	wire logic acc = psel && penable;
	wire logic wr = acc && pwrite;
	wire logic rd = acc && !pwrite;
	// read data launched at setup so it stands through the access cycle
	wire logic setup_rd = psel && !penable && !pwrite;
	wire logic sel_mode = paddr == cssc_pkg::ADDR_MODE;
	wire logic sel_ctrl = paddr == cssc_pkg::ADDR_CTRL;
	wire logic sel_data = paddr == cssc_pkg::ADDR_DATA;
	wire logic sel_stat = paddr == cssc_pkg::ADDR_STAT;
	wire logic sel_mask = paddr == cssc_pkg::ADDR_MASK;
	wire logic sel_clr = paddr == cssc_pkg::ADDR_CLR;
	wire logic mapped = sel_mode || sel_ctrl || sel_data || sel_stat || sel_mask || sel_clr;
	wire logic rx_en = communication_control_register[cssc_pkg::CTRL_RXE];
	wire logic ext_clk = channel_mode_register[cssc_pkg::MODE_EXTCLK];
	wire logic inv_in = channel_mode_register[cssc_pkg::MODE_INV];
	wire logic isrc = channel_mode_register[cssc_pkg::MODE_ISRC];
	wire logic phase_sel = communication_control_register[cssc_pkg::CTRL_PHASE];
	wire logic pol_sel = communication_control_register[cssc_pkg::CTRL_POL];
	wire logic lsb_first = communication_control_register[cssc_pkg::CTRL_DIR];
	wire logic [3:0] word_len = communication_control_register[cssc_pkg::CTRL_DLS0]
		? cssc_pkg::LEN_EIGHT : cssc_pkg::LEN_SEVEN;
	// polarity-corrected clock; capture edge chosen by phase
	wire logic sclk_n = sync.sclk ^ pol_sel;
	wire logic sclk_p = sclk_d ^ pol_sel;
	wire logic rise = sclk_n && !sclk_p;
	wire logic fall = !sclk_n && sclk_p;
	wire logic cap = ext_clk && rx_en && (phase_sel ? fall : rise);
	wire logic din = sync.sdi ^ inv_in;
	wire logic last = bit_cnt == word_len - 4'h1;
	wire logic word_done = state == cssc_pkg::CSSC_SHIFT && cap && last;
	wire logic [DATA_W-1:0] next_shift = ins_bit(shift, din, lsb_first, word_len);
	// buffer-empty event suppressed in receive; end-of-transfer always allowed
	assign ev.end_of_xfer = word_done;
	assign ev.overrun = word_done && buffer_full_flag;
	assign ev.empty = word_done && isrc && !rx_en;
	wire logic [2:0] ev_vec = {ev.empty, ev.overrun, ev.end_of_xfer};
	wire logic [2:0] stat_view = {busy, ev_stat[cssc_pkg::EV_OVR], buffer_full_flag};
	wire logic rd_stat = rd && sel_stat;
	wire logic clr_wr = wr && sel_clr;
	// a status read clears only the events that its data showed
	wire logic [2:0] ev_kept = rd_stat ? (ev_stat & ~ev_seen)
		: clr_wr ? cssc_pkg::EV_RESET : ev_stat;
	wire logic [31:0] rd_mux = sel_mode ? {16'h0000, channel_mode_register}
		: sel_ctrl ? {16'h0000, communication_control_register}
		: sel_data ? {24'h000000, channel_data_register}
		: sel_stat ? {26'h0, ev_stat, stat_view}
		: sel_mask ? {29'h0, ev_mask}
		: 32'h00000000;

	assign pready = 1'b1;
	assign pslverr = acc && !mapped;
	assign transfer_end_interrupt = |(ev_stat & ev_mask);

	// ----------------------------------------
	// link synchroniser
	// ----------------------------------------
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			meta <= '0;
			sync <= '0;
			sclk_d <= 1'b0;
		end
		else
		begin
			meta <= {serial_clock_pin, serial_data_in_pin};
			sync <= meta;
			sclk_d <= sync.sclk;
		end
	end

	// ----------------------------------------
	// apb registers
	// ----------------------------------------
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			channel_mode_register <= cssc_pkg::MODE_RESET;
			communication_control_register <= cssc_pkg::CTRL_RESET;
			ev_mask <= cssc_pkg::EV_RESET;
			prdata <= 32'h00000000;
			ev_seen <= cssc_pkg::EV_RESET;
			data_fresh <= 1'b0;
		end
		else
		begin
			if (wr && sel_mode)
			begin
				channel_mode_register <= pwdata[15:0] & cssc_pkg::MODE_MASK;
			end
			if (wr && sel_ctrl)
			begin
				communication_control_register <= pwdata[15:0] & cssc_pkg::CTRL_MASK;
			end
			if (wr && sel_mask)
			begin
				ev_mask <= pwdata[2:0];
			end
			if (setup_rd)
			begin
				prdata <= rd_mux;
				ev_seen <= ev_stat;
				data_fresh <= !word_done;
			end
		end
	end

	// ----------------------------------------
	// status, read clears, set wins
	// ----------------------------------------
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			ev_stat <= cssc_pkg::EV_RESET;
		end
		else
		begin
			ev_stat <= ev_kept | ev_vec;
		end
	end

	// ----------------------------------------
	// data buffer
	// ----------------------------------------
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			channel_data_register <= '0;
			buffer_full_flag <= 1'b0;
		end
		else if (word_done)
		begin
			channel_data_register <= align(next_shift, lsb_first, word_len);
			buffer_full_flag <= 1'b1;
		end
		else if (wr && sel_data)
		begin
			channel_data_register <= pwdata[DATA_W-1:0];
			buffer_full_flag <= 1'b1;
		end
		else if (rd && sel_data && data_fresh)
		begin
			buffer_full_flag <= 1'b0;
		end
	end

	// ----------------------------------------
	// receive shifter
	// ----------------------------------------
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			state <= cssc_pkg::CSSC_IDLE;
			shift <= '0;
			bit_cnt <= cssc_pkg::CNT_ZERO;
			busy <= 1'b0;
		end
		else
		begin
			case (state)
				cssc_pkg::CSSC_IDLE:
				begin
					busy <= 1'b0;
					bit_cnt <= cssc_pkg::CNT_ZERO;
					if (rx_en && ext_clk)
					begin
						state <= cssc_pkg::CSSC_SHIFT;
					end
				end
				cssc_pkg::CSSC_SHIFT:
				begin
					if (!rx_en)
					begin
						state <= cssc_pkg::CSSC_IDLE;
					end
					else if (cap)
					begin
						shift <= next_shift;
						busy <= !last;
						bit_cnt <= last ? cssc_pkg::CNT_ZERO : bit_cnt + 4'h1;
						if (last)
						begin
							state <= cssc_pkg::CSSC_DONE;
						end
					end
				end
				cssc_pkg::CSSC_DONE:
				begin
					state <= cssc_pkg::CSSC_SHIFT;
				end
				default:
				begin
					state <= cssc_pkg::CSSC_IDLE;
				end
			endcase
		end
	end
endmodule : cssc_slave

// *** testbench/clocked_serial_slave_channel_bench.sv ***
`timescale 1ns/1ps
module clocked_serial_slave_channel_bench;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pol = 0, m = 1, err;
	logic [7:0] paddr = 8'h0;
	logic [31:0] pwdata = 32'h0, prdata, r, v, c;
	logic pready, pslverr, irq, sclk, sdi;
	int failures = 0, tests_run = 0, cyc = 0, ov = 0, q[$];
	always #2.5 pclk = ~pclk;
	cssc_slave dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .serial_clock_pin(sclk), .serial_data_in_pin(sdi),
		.transfer_end_interrupt(irq));
	cssc_master_model master_u (.pol(pol), .sclk(sclk), .sdi(sdi));
	// ----
	// tasks
	// ----
	task automatic finish_test();
		if (failures == 0 && tests_run > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : finish_test
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		tests_run++;
		if (s !== e)
		begin
			failures++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask : chk
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do
		begin
			@(posedge pclk);
		end
		while (pready !== 1'b1);
		r = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic frame(input logic [7:0] d, input int n, input logic lsb);
		int k;
		k = 0;
		ov = q.size() > 0;
		q = {};
		q.push_back(n == 8 ? d : d & 8'h7f);
		master_u.send(d, n, lsb);
		while (irq !== m && k < 40)
		begin
			@(posedge pclk);
			k++;
		end
		chk({31'h0, irq}, {31'h0, m});
	endtask : frame
	task automatic take();
		apb(0, cssc_pkg::ADDR_STAT, 0);
		chk(r & 32'h3b, ov ? 32'h1b : 32'h09);
		apb(0, cssc_pkg::ADDR_DATA, 0);
		chk(r, q.pop_front());
		chk({31'h0, irq}, 32'h0);
		ov = 0;
	endtask : take
	always @(posedge pclk)
	begin
		cyc <= cyc + 1;
		if (cyc == 20000)
		begin
			failures++;
			finish_test();
		end
	end
	// ----
	// main sequence
	// ----
	initial
	begin
		v = $urandom(32'h0f43);
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		apb(0, cssc_pkg::ADDR_MODE, 0);
		chk(r, 32'h20);
		apb(0, cssc_pkg::ADDR_CTRL, 0);
		chk(r, 32'h7);
		apb(0, 8'h20, 0);
		chk({r[30:0], err}, 32'h1);
		v = $urandom & 32'hfffe;
		apb(1, cssc_pkg::ADDR_MODE, v);
		apb(0, cssc_pkg::ADDR_MODE, 0);
		chk(r, v & {16'h0, cssc_pkg::MODE_MASK});
		apb(1, cssc_pkg::ADDR_MODE, 32'h4020);
		apb(1, cssc_pkg::ADDR_MASK, 32'h1);
		apb(1, cssc_pkg::ADDR_DATA, 32'h5a);
		apb(1, cssc_pkg::ADDR_DATA, 32'ha5);
		apb(0, cssc_pkg::ADDR_STAT, 0);
		chk(r & 32'h3b, 32'h01);
		apb(0, cssc_pkg::ADDR_DATA, 0);
		chk(r, 32'ha5);
		apb(0, cssc_pkg::ADDR_STAT, 0);
		chk(r & 32'h3b, 32'h00);
		for (int i = 0; i < 8; i++)
		begin
			c = (i % 2) << 13 | (i / 2 % 2) << 12 | (i / 4) << 7 | (i != 2 && i != 5);
			apb(1, cssc_pkg::ADDR_CTRL, c);
			pol <= c[12];
			apb(1, cssc_pkg::ADDR_CTRL, c | 32'h4000);
			frame(8'($urandom), (i == 2 || i == 5) ? 7 : 8, c[7]);
			take();
		end
		frame(8'($urandom), 8, 1'b1);
		frame(8'($urandom), 8, 1'b1);
		take();
		m = 1'b0;
		apb(1, cssc_pkg::ADDR_MASK, 32'h0);
		frame(8'($urandom), 8, 1'b1);
		take();
		apb(1, cssc_pkg::ADDR_CTRL, c);
		master_u.send(8'($urandom), 8, 1'b1);
		repeat (8) @(posedge pclk);
		apb(0, cssc_pkg::ADDR_STAT, 0);
		chk(r & 32'h3b, 32'h0);
		finish_test();
	end
endmodule : clocked_serial_slave_channel_bench

// *** testbench/cssc_master_model.sv ***
`timescale 1ns/1ps
module cssc_master_model (
	// idle level of pin
	input wire logic pol,
	// serial link
	output logic sclk,
	output logic sdi
);
	logic ph = 1'b0;
	initial sdi = 1'b0;
	assign sclk = pol ^ ph; // clock stands still between frames
	task automatic send(input logic [7:0] v, input int n, input logic lsb);
		for (int i = 0; i < n; i++)
		begin
			#16 sdi = lsb ? v[i] : v[n - 1 - i]; // data moves mid low phase
			#16 ph = 1'b1; // 64 ns period, above six pclk
			#32 ph = 1'b0;
		end
		#16 sdi = ~sdi;
	endtask : send
endmodule : cssc_master_model

// *** testbench/cssc_slave_properties.sv ***
`timescale 1ns/1ps
module cssc_slave_properties (
	// apb
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// link and interrupt
	input wire logic serial_clock_pin,
	input wire logic transfer_end_interrupt
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// ----
	// cycles since last pin edge
	// ----
	logic sclk_q;
	logic [3:0] since_sclk;
	wire chg = sclk_q != serial_clock_pin;
	wire [3:0] next_since = chg ? 4'h0 : since_sclk + {3'h0, since_sclk != 4'hf};
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			sclk_q <= 1'b0;
			since_sclk <= 4'hf;
		end
		else
		begin
			sclk_q <= serial_clock_pin;
			since_sclk <= next_since;
		end
	end
	sequence s_acc;
		psel && penable;
	endsequence
	sequence s_bad_rd;
		psel && penable && !pwrite && paddr > 8'h14;
	endsequence
	property p_ready;
		s_acc |-> pready;
	endproperty
	property p_err_bad;
		psel && penable && paddr > 8'h14 |-> pslverr;
	endproperty
	property p_err_ok;
		psel && penable && paddr <= 8'h14 && paddr[1:0] == 2'b00 |-> !pslverr;
	endproperty
	property p_err_idle;
		!(psel && penable) |-> !pslverr;
	endproperty
	property p_bad_zero;
		s_bad_rd |=> prdata == 32'h0;
	endproperty
	property p_rd_hold;
		!$stable(prdata) |-> $past(psel && !pwrite);
	endproperty
	property p_irq_fall;
		$fell(transfer_end_interrupt) |-> $past(psel && penable) || $past(psel && penable, 2);
	endproperty
	property p_irq_rise;
		$rose(transfer_end_interrupt) |-> since_sclk < 4'hc || $past(psel && pwrite)
			|| $past(psel && pwrite, 2);
	endproperty
	a_ready: assert property (p_ready) else $error("access not completed at once");
	a_err_bad: assert property (p_err_bad) else $error("unmapped access not refused");
	a_err_ok: assert property (p_err_ok) else $error("mapped access refused");
	a_err_idle: assert property (p_err_idle) else $error("error outside access");
	a_bad_zero: assert property (p_bad_zero) else $error("unmapped read not zero");
	a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
	a_irq_fall: assert property (p_irq_fall) else $error("irq fell alone");
	a_irq_rise: assert property (p_irq_rise) else $error("irq without cause");
endmodule : cssc_slave_properties
bind cssc_slave cssc_slave_properties props_u (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
	.pslverr(pslverr), .serial_clock_pin(serial_clock_pin),
	.transfer_end_interrupt(transfer_end_interrupt));
